// File: scg_global_regs.sv
`include "scg_defines.svh"

// How it works
// - Receive-accept write frees buffer on running channels
// - Bit n belongs to channel n
// - Receive-accept ignored for on-board ring channels
// - Break bit plus trigger sends break on running channels
// - Break bit clears when break starts
// - Break holds spacing for programmed milliseconds
// - Bits 7-6 request level, default 3
// - Bits 5-4 release policy, default 00
// - Fairness wait in 2 us steps; 15 forever
// - Fairness default 0010, one extra step allowed
// - Width code 00/10/01 gives 32/16/8 bits
// - Bits 5-0 drive AM5-AM0 unchanged
// - Width/modifier resets to b9
// - Run-tests trigger runs selected tests, bit5 first
// - Break trigger clears once breaks on all running channels have started
// - Tests end or fail clears run trigger
// - Run bit set clears receive-accept bit
module scg_global_regs #(
  parameter int NCH        = 16,
  parameter int DUR_W      = 8,
  parameter int MS_CYCLES  = `SCG_MS_NS / `SCG_CLK_NS,
  parameter int FAIR_CYC   = `SCG_FAIR_NS / `SCG_CLK_NS
) (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  // Register port
  input  wire scg_pkg::scg_req_t            reg_req,
  output logic [15:0]                       reg_rdata_r,
  output logic                              reg_ack_r,
  // Channel engines
  input  wire logic [NCH-1:0]               run_bits,
  input  wire logic [NCH-1:0]               run_set,
  input  wire logic [NCH-1:0]               onboard_ring_select,
  input  wire logic [NCH-1:0]               rx_taken,
  input  wire logic [NCH-1:0][DUR_W-1:0]    break_duration,
  output logic [NCH-1:0]                    break_line_r,
  output logic [NCH-1:0]                    rx_accept_r,
  // Break trigger
  input  wire logic                         send_break_set,
  output logic                              send_break_trigger_r,
  // Bus master
  input  wire logic                         need_bus,
  input  wire logic                         bus_busy_other,
  input  wire logic                         bus_granted,
  output logic                              bus_request_r,
  output scg_pkg::scg_bus_ctrl_t            bus_ctrl_r,
  output scg_pkg::scg_width_am_t            width_am_r,
  // Self test
  input  wire logic                         run_tests_set,
  input  wire logic                         test_done,
  input  wire logic                         test_fail,
  output logic                              run_tests_trigger_r,
  output logic                              test_start_r,
  output logic [2:0]                        test_id_r,
  output logic                              test_failed_r
);
  import scg_pkg::*;

  typedef enum logic [1:0] {BR_IDLE, BR_WAIT, BR_REQ} scg_bus_st_t;
  typedef enum logic [1:0] {TS_IDLE, TS_PICK, TS_WAIT} scg_test_st_t;
  logic [NCH-1:0]   brk_req_r;
  logic [7:0]       test_sel_r;
  logic [DUR_W:0]   brk_cnt_r [NCH];
  logic [NCH-1:0]   brk_start;
  logic [31:0]      ms_div_r;
  logic             ms_tick_r;
  logic [31:0]      fair_div_r;
  logic             fair_tick_r;
  logic [3:0]       fair_cnt_r;
  scg_bus_st_t      bus_st_r;
  scg_test_st_t     test_st_r;
  logic [5:0]       test_left_r;
  logic             wr_hi;
  logic             wr_lo;
  logic [4:0]       word_addr;
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a[4:1] == off[4:1]);
  endfunction
  function automatic logic [2:0] top_bit(input logic [5:0] m);
    top_bit = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (m[i]) top_bit = 3'(i);
    end
  endfunction
  // Even byte is the upper lane on this big-endian bus
  assign word_addr = {reg_req.addr[4:1], 1'b0};
  assign wr_hi     = reg_req.wr && reg_req.be[1];
  assign wr_lo     = reg_req.wr && reg_req.be[0];

  // Read data and acknowledge, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_r <= 16'h0000;
      reg_ack_r   <= 1'b0;
    end else begin
      reg_ack_r <= reg_req.rd || reg_req.wr;
      if (reg_req.rd) begin
        if (hit(word_addr, `SCG_OFF_RX_ACCEPT))
          reg_rdata_r <= rx_accept_r;
        else if (hit(word_addr, `SCG_OFF_BRK_REQ))
          reg_rdata_r <= brk_req_r;
        else if (hit(word_addr, `SCG_OFF_BUS_CTRL))
          reg_rdata_r <= {bus_ctrl_r, 8'h00};
        else if (hit(word_addr, `SCG_OFF_WIDTH_AM))
          reg_rdata_r <= {width_am_r, test_sel_r & `SCG_TEST_SEL_MASK};
        else
          reg_rdata_r <= 16'h0000;
      end
    end
  end

  // Receive-accept bits; writes outside running, non-ring channels do nothing
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_rx
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          rx_accept_r[c] <= 1'b0;
        end else if (hit(word_addr, `SCG_OFF_RX_ACCEPT) && (c < 8 ? wr_lo : wr_hi)
                     && run_bits[c] && !onboard_ring_select[c]) begin
          rx_accept_r[c] <= reg_req.wdata[c];
        end else if (run_set[c] || rx_taken[c]) begin
          rx_accept_r[c] <= 1'b0;
        end
      end
    end
  endgenerate
  // Millisecond divider shared by all break timers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ms_div_r  <= 32'h0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (ms_div_r == 32'(MS_CYCLES - 1));
      ms_div_r  <= (ms_div_r == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_div_r + 32'h1;
    end
  end

  // Break requests and per-channel timers
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_brk
      assign brk_start[c] = send_break_trigger_r && brk_req_r[c] && run_bits[c]
                            && (brk_cnt_r[c] == '0);
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          brk_req_r[c] <= 1'b0;
        end else if (hit(word_addr, `SCG_OFF_BRK_REQ) && (c < 8 ? wr_lo : wr_hi)) begin
          brk_req_r[c] <= reg_req.wdata[c];
        end else if (brk_start[c]) begin
          brk_req_r[c] <= 1'b0;
        end
      end
      // One extra ms so the free-running tick never shortens the break
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          brk_cnt_r[c]    <= '0;
          break_line_r[c] <= 1'b0;
        end else begin
          if (brk_start[c])
            brk_cnt_r[c] <= {1'b0, break_duration[c]} + (DUR_W+1)'(1);
          else if (ms_tick_r && brk_cnt_r[c] != '0)
            brk_cnt_r[c] <= brk_cnt_r[c] - (DUR_W+1)'(1);
          break_line_r[c] <= brk_start[c] ||
                             (brk_cnt_r[c] > (DUR_W+1)'(1)) ||
                             (brk_cnt_r[c] == (DUR_W+1)'(1) && !ms_tick_r);
        end
      end
    end
  endgenerate

  // Global break trigger; a new set wins over the automatic clear
  always_ff @(posedge clk_sys) begin
    if (rst)
      send_break_trigger_r <= 1'b0;
    else if (send_break_set)
      send_break_trigger_r <= 1'b1;
    else if (send_break_trigger_r && (brk_req_r & run_bits) == '0 && brk_start == '0)
      send_break_trigger_r <= 1'b0;
  end

  // Bus-master control, width/modifier and test-select bytes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_ctrl_r <= `SCG_RST_BUS_CTRL;
      width_am_r <= `SCG_RST_WIDTH_AM;
      test_sel_r <= `SCG_RST_TEST_SEL;
    end else begin
      if (hit(word_addr, `SCG_OFF_BUS_CTRL) && wr_hi)
        bus_ctrl_r <= reg_req.wdata[15:8];
      if (hit(word_addr, `SCG_OFF_WIDTH_AM) && wr_hi)
        width_am_r <= reg_req.wdata[15:8];
      if (hit(word_addr, `SCG_OFF_TEST_SEL) && wr_lo)
        test_sel_r <= reg_req.wdata[7:0] & `SCG_TEST_SEL_MASK;
    end
  end
  // Free-running 2 us tick, so a wait may run one step long
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fair_div_r  <= 32'h0;
      fair_tick_r <= 1'b0;
    end else begin
      fair_tick_r <= (fair_div_r == 32'(FAIR_CYC - 1));
      fair_div_r  <= (fair_div_r == 32'(FAIR_CYC - 1)) ? 32'h0 : fair_div_r + 32'h1;
    end
  end

  // Fair bus request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_st_r      <= BR_IDLE;
      fair_cnt_r    <= 4'h0;
      bus_request_r <= 1'b0;
    end else begin
      unique case (bus_st_r)
        BR_IDLE: begin
          if (need_bus) begin
            if (bus_busy_other && bus_ctrl_r.fairness_wait_field != `SCG_FAIR_OFF) begin
              bus_st_r   <= BR_WAIT;
              fair_cnt_r <= bus_ctrl_r.fairness_wait_field;
            end else begin
              bus_st_r      <= BR_REQ;
              bus_request_r <= 1'b1;
            end
          end
        end
        BR_WAIT: begin
          if (!need_bus) begin
            bus_st_r <= BR_IDLE;
          end else if (!bus_busy_other || (fair_cnt_r == 4'h0 && fair_tick_r)) begin
            bus_st_r      <= BR_REQ;
            bus_request_r <= 1'b1;
          end else if (fair_tick_r && fair_cnt_r != `SCG_FAIR_FOREVER) begin
            fair_cnt_r <= fair_cnt_r - 4'h1;
          end
        end
        BR_REQ: begin
          if (bus_granted || !need_bus) begin
            bus_st_r      <= BR_IDLE;
            bus_request_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Self-test sequencer, highest selected bit first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      test_st_r           <= TS_IDLE;
      test_left_r         <= 6'h00;
      run_tests_trigger_r <= 1'b0;
      test_start_r        <= 1'b0;
      test_id_r           <= 3'h0;
      test_failed_r       <= 1'b0;
    end else begin
      test_start_r <= 1'b0;
      unique case (test_st_r)
        TS_IDLE: begin
          if (run_tests_set) begin
            run_tests_trigger_r <= 1'b1;
            test_failed_r       <= 1'b0;
            test_left_r         <= test_sel_r[5:0];
            test_st_r           <= TS_PICK;
          end
        end
        TS_PICK: begin
          if (test_left_r == 6'h00) begin
            run_tests_trigger_r <= 1'b0;
            test_st_r           <= TS_IDLE;
          end else begin
            test_id_r    <= top_bit(test_left_r);
            test_start_r <= 1'b1;
            test_st_r    <= TS_WAIT;
          end
        end
        TS_WAIT: begin
          if (test_done) begin
            test_left_r[test_id_r] <= 1'b0;
            if (test_fail) begin
              test_failed_r       <= 1'b1;
              run_tests_trigger_r <= 1'b0;
              test_st_r           <= TS_IDLE;
            end else begin
              test_st_r <= TS_PICK;
            end
          end
        end
      endcase
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_brk_clear;
    brk_start[0] && !(hit(word_addr, `SCG_OFF_BRK_REQ) && wr_lo) |=> !brk_req_r[0];
  endproperty
  a_brk_clear: assert property (p_brk_clear) else $error("break bit not cleared");
  // A zero duration may legally end after one cycle
  property p_brk_line;
    brk_start[0] && break_duration[0] != '0 |=> break_line_r[0] [*2];
  endproperty
  a_brk_line: assert property (p_brk_line) else $error("break line not held");
  property p_trig_clear;
    send_break_trigger_r && (brk_req_r & run_bits) == '0 && brk_start == '0
      && !send_break_set |=> !send_break_trigger_r;
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared");
  property p_rx_ignore;
    (rx_accept_r & ~$past(rx_accept_r) & ~$past(run_bits & ~onboard_ring_select)) == '0;
  endproperty
  a_rx_ignore: assert property (p_rx_ignore) else $error("ignored bit set");
  property p_run_clear;
    run_set != '0 && !(hit(word_addr, `SCG_OFF_RX_ACCEPT) && reg_req.wr)
      |=> (rx_accept_r & $past(run_set)) == '0;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run set kept bit");
  property p_reset_vals;
    $past(rst) |-> width_am_r == `SCG_RST_WIDTH_AM && bus_ctrl_r == `SCG_RST_BUS_CTRL;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  property p_fair_wait;
    bus_st_r == BR_IDLE && need_bus && bus_busy_other
      && bus_ctrl_r.fairness_wait_field != `SCG_FAIR_OFF |=> !bus_request_r;
  endproperty
  a_fair_wait: assert property (p_fair_wait) else $error("request during wait");
  property p_test_fail;
    test_st_r == TS_WAIT && test_done && test_fail |=> !run_tests_trigger_r && test_failed_r;
  endproperty
  a_test_fail: assert property (p_test_fail) else $error("fail did not stop");
  property p_test_start;
    test_st_r == TS_PICK && test_left_r != 6'h00 |=> test_start_r ##1 !test_start_r;
  endproperty
  a_test_start: assert property (p_test_start) else $error("bad test start");
endmodule

// File: scg_defines.svh
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH
// Byte offsets on the global register space, big-endian 16-bit words
`define SCG_OFF_RX_ACCEPT  5'h0a
`define SCG_OFF_BRK_REQ    5'h0c
`define SCG_OFF_BUS_CTRL   5'h0e
`define SCG_OFF_WIDTH_AM   5'h10
`define SCG_OFF_TEST_SEL   5'h11
// Reset values
`define SCG_RST_BUS_CTRL   8'hc2
`define SCG_RST_WIDTH_AM   8'hb9
`define SCG_RST_TEST_SEL   8'h00
`define SCG_TEST_SEL_MASK  8'h3f
// Fairness code meaning wait without limit
`define SCG_FAIR_FOREVER   4'hf
`define SCG_FAIR_OFF       4'h0
// Timing in ns
`define SCG_CLK_NS         50
`define SCG_MS_NS          1000000
`define SCG_FAIR_NS        2000
`endif

// File: scg_pkg.sv
package scg_pkg;
  typedef struct packed {
    logic [1:0] request_level_field;
    logic [1:0] release_policy_field;
    logic [3:0] fairness_wait_field;
  } scg_bus_ctrl_t;

  typedef struct packed {
    logic [1:0] transfer_width_field;
    logic [5:0] modifier_code_field;
  } scg_width_am_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } scg_req_t;

  typedef enum logic [1:0] {
    SCG_RELEASE_ON_REQUEST = 2'h0,
    SCG_RELEASE_WHEN_DONE  = 2'h1,
    SCG_RELEASE_ON_CLEAR   = 2'h2,
    SCG_CAPTURE_AND_HOLD   = 2'h3
  } scg_release_t;

  typedef enum logic [1:0] {
    SCG_WIDTH_32 = 2'h0,
    SCG_WIDTH_8  = 2'h1,
    SCG_WIDTH_16 = 2'h2
  } scg_width_t;
endpackage

// File: scg_far_model.sv
module scg_far_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Bus arbiter side
  input  wire logic       bus_request_r,
  output logic            bus_granted,
  // Test engine side
  input  wire logic       test_start_r,
  input  wire logic [2:0] test_id_r,
  input  wire logic [2:0] fail_id,
  output logic            test_done,
  output logic            test_fail
);
  logic       gnt_r;
  logic [2:0] dly_r;
  logic [2:0] id_r;
  // Grant two cycles late, as a loaded arbiter would
  always_ff @(posedge clk_sys) begin
    gnt_r       <= rst ? 1'b0 : bus_request_r;
    bus_granted <= rst ? 1'b0 : gnt_r & bus_request_r;
  end
  // Each test takes a few cycles; fail flag valid only with done
  always_ff @(posedge clk_sys) begin
    test_done <= 1'b0;
    test_fail <= 1'b0;
    if (rst) begin
      dly_r <= 3'h0;
    end else if (test_start_r) begin
      dly_r <= 3'h4;
      id_r  <= test_id_r;
    end else if (dly_r != 3'h0) begin
      dly_r <= dly_r - 3'h1;
      if (dly_r == 3'h1) begin
        test_done <= 1'b1;
        test_fail <= (id_r == fail_id);
      end
    end
  end
endmodule

// File: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import scg_pkg::*;
  logic                  clk_sys, rst, send_break_set, send_break_trigger_r;
  logic                  reg_ack_r, need_bus, bus_busy_other, bus_granted, bus_request_r;
  logic                  run_tests_set, test_done, test_fail, run_tests_trigger_r;
  logic                  test_start_r, test_failed_r;
  logic [2:0]            test_id_r, fail_id;
  logic [15:0]           reg_rdata_r, run_bits, run_set, ring_sel, rx_taken;
  logic [15:0]           break_line_r, rx_accept_r;
  logic [15:0][7:0]      break_duration;
  scg_req_t              reg_req;
  scg_bus_ctrl_t         bus_ctrl_r;
  scg_width_am_t         width_am_r;
  int                    errors, checks_done, n, i;

  // Break timing shortened to 20 cycles per ms
  scg_global_regs #(.MS_CYCLES(20), .FAIR_CYC(40)) u_scg_global_regs (
    .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
    .reg_ack_r(reg_ack_r), .run_bits(run_bits), .run_set(run_set),
    .onboard_ring_select(ring_sel), .rx_taken(rx_taken), .break_duration(break_duration),
    .break_line_r(break_line_r), .rx_accept_r(rx_accept_r), .send_break_set(send_break_set),
    .send_break_trigger_r(send_break_trigger_r), .need_bus(need_bus),
    .bus_busy_other(bus_busy_other), .bus_granted(bus_granted),
    .bus_request_r(bus_request_r), .bus_ctrl_r(bus_ctrl_r), .width_am_r(width_am_r),
    .run_tests_set(run_tests_set), .test_done(test_done), .test_fail(test_fail),
    .run_tests_trigger_r(run_tests_trigger_r), .test_start_r(test_start_r),
    .test_id_r(test_id_r), .test_failed_r(test_failed_r));

  scg_far_model u_scg_far_model (
    .clk_sys(clk_sys), .rst(rst), .bus_request_r(bus_request_r), .bus_granted(bus_granted),
    .test_start_r(test_start_r), .test_id_r(test_id_r), .fail_id(fail_id),
    .test_done(test_done), .test_fail(test_fail));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle strobe; ack must follow on the next edge
  task automatic wr(input logic [4:0] a, input logic [1:0] b, input logic [15:0] d);
    @(posedge clk_sys) reg_req <= {1'b0, 1'b1, a, b, d};
    @(posedge clk_sys) reg_req <= '0;
    #1 chk(reg_ack_r, 1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_sys) reg_req <= {1'b1, 1'b0, a, 2'b11, 16'h0000};
    @(posedge clk_sys) reg_req <= '0;
    #1 chk(reg_ack_r, 1);
    chk(reg_rdata_r, e);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return break_line_r[0];
      1: return !break_line_r[0];
      2: return bus_request_r;
      3: return test_start_r;
      default: return !run_tests_trigger_r;
    endcase
  endfunction

  // Bounded wait; running out counts as a mismatch
  task automatic wt(input int s, input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge clk_sys);
      #1;
      if (sig(s)) break;
    end
    if (n >= lim) begin
      errors++;
      stop_test();
    end
  endtask

  task automatic selftest(input logic [7:0] sel, input logic [2:0] a, input logic [2:0] b,
                          input logic f);
    wr(5'h10, 2'b01, {8'h00, sel});
    @(posedge clk_sys) run_tests_set <= 1'b1;
    @(posedge clk_sys) run_tests_set <= 1'b0;
    wt(3, 20);
    chk(test_id_r, a);
    wt(3, 20);
    chk(test_id_r, b);
    wt(4, 20);
    chk(test_failed_r, f);
  endtask

  task automatic fair_wait(input logic [15:0] ctrl);
    wr(5'h0e, 2'b10, ctrl);
    @(posedge clk_sys);
    need_bus       <= 1'b1;
    bus_busy_other <= 1'b1;
    wt(2, 200);
  endtask

  initial begin
    errors = 0;
    checks_done = 0;
    rst <= 1'b1;
    reg_req <= '0;
    run_bits <= 16'h00ff;
    run_set <= '0;
    ring_sel <= 16'h000f;
    rx_taken <= '0;
    break_duration <= {16{8'h01}};
    send_break_set <= 1'b0;
    need_bus <= 1'b0;
    bus_busy_other <= 1'b0;
    run_tests_set <= 1'b0;
    fail_id <= 3'h7;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk(width_am_r, 8'hb9);
    rd(5'h0e, 16'hc200);
    rd(5'h10, 16'hb900);
    rd(5'h1e, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wr(5'h0e, 2'b10, {2'h3, i[1:0], 4'h2, 8'h00});
      chk(bus_ctrl_r.release_policy_field, i[1:0]);
    end
    for (i = 0; i < 3; i++) begin
      wr(5'h10, 2'b10, {i[1:0], 6'h3d, 8'h00});
      chk(width_am_r, {i[1:0], 6'h3d});
    end
    wr(5'h10, 2'b01, 16'h00ff);
    rd(5'h10, 16'hbd3f);
    // Read then write, as the host would for these bits
    rd(5'h0a, 16'h0000);
    wr(5'h0a, 2'b11, 16'hffff);
    chk(rx_accept_r, 16'h00f0);
    @(posedge clk_sys) run_set <= 16'h0010;
    @(posedge clk_sys) run_set <= '0;
    #1 chk(rx_accept_r, 16'h00e0);
    @(posedge clk_sys) rx_taken <= 16'h0020;
    @(posedge clk_sys) rx_taken <= '0;
    #1 chk(rx_accept_r, 16'h00c0);
    // Channel 8 not running: its bit must stay pending
    wr(5'h0c, 2'b11, 16'h0101);
    @(posedge clk_sys) send_break_set <= 1'b1;
    @(posedge clk_sys) send_break_set <= 1'b0;
    wt(0, 10);
    wt(1, 100);
    chk(n >= 19 && n <= 40, 1);
    chk(send_break_trigger_r, 0);
    chk(break_line_r[8], 0);
    rd(5'h0c, 16'h0100);
    fair_wait(16'hc200);
    chk(n >= 78 && n <= 123, 1);
    @(posedge clk_sys) need_bus <= 1'b0;
    repeat (4) @(posedge clk_sys);
    fair_wait(16'hc000);
    chk(n <= 2, 1);
    @(posedge clk_sys) need_bus <= 1'b0;
    wr(5'h0e, 2'b10, 16'hcf00);
    @(posedge clk_sys) need_bus <= 1'b1;
    repeat (300) @(posedge clk_sys);
    #1 chk(bus_request_r, 0);
    @(posedge clk_sys) bus_busy_other <= 1'b0;
    wt(2, 5);
    @(posedge clk_sys) need_bus <= 1'b0;
    selftest(8'h24, 3'h5, 3'h2, 1'b0);
    @(posedge clk_sys) fail_id <= 3'h4;
    selftest(8'h3f, 3'h5, 3'h4, 1'b1);
    stop_test();
  end
endmodule
